// ==== fst_params.svh ====
`ifndef FST_PARAMS_SVH
`define FST_PARAMS_SVH

// ==========================================================
// Command codes
`define FST_CMD_CLEAR_FAULTS   8'h03
`define FST_CMD_ALERT1_MASK    8'h1B
`define FST_CMD_STATUS_BYTE    8'h78
`define FST_CMD_STATUS_WORD    8'h79
`define FST_CMD_BUS_VOLTAGE_FAULT_STATUS    8'h7A
`define FST_CMD_OVERCURRENT_FAULT_STATUS    8'h7B
`define FST_CMD_STATUS_TEMP    8'h7D
`define FST_CMD_COMM_ERROR_STATUS     8'h7E
`define FST_CMD_CFG_INTR       8'hDD
`define FST_CMD_ALERT_POLFORCE 8'hDE
`define FST_CMD_ALERT2_MASK    8'hDF

// ==========================================================
// Field positions
`define FST_BIT_OVERVOLTAGE_COMPARATOR_ENABLE      1
`define FST_BIT_UNDERVOLTAGE_COMPARATOR_ENABLE      0
`define FST_BIT_OVERCURRENT_COMPARATOR_ENABLE      2
`define FST_BIT_SECOND_ALERT_POLARITY      3
`define FST_BIT_FIRST_ALERT_POLARITY      2
`define FST_BIT_SECOND_ALERT_FORCE    1
`define FST_BIT_FIRST_ALERT_FORCE    0
`define FST_BIT_VOUT_OV    6
`define FST_BIT_VOUT_UV    5
`define FST_BIT_IOUT_OC    5
`define FST_BIT_TEMP_OT    6
`define FST_BIT_CML_UNSUPPORTED_COMMAND_FLAG  7
`define FST_BIT_CML_UNSUPPORTED_PAYLOAD_FLAG 6
`define FST_BIT_CML_PEC    5
`define FST_BIT_CML_GENERAL_LINK_ERROR_FLAG 1
`define FST_BIT_SB_BUSY    7
`define FST_BIT_SB_TEMP    2
`define FST_BIT_SB_CML     1
`define FST_BIT_SW_VOUT    15
`define FST_BIT_SW_IOUT    14

// ==========================================================
// Reset values
`define FST_RST_STATUS     8'h00
`define FST_RST_CFG        3'h0
`define FST_RST_POLFORCE   4'h0
`define FST_RST_MASK       16'hFFFF

`endif

// ==== fst_pkg.sv ====
package fst_pkg;

  // ==========================================================
  // Decoded host transaction from the serial front end
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic        pec_bad;
    logic [7:0]  code;
    logic [15:0] data;
  } fst_cmd_t;

  // Read answer back to the front end
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } fst_rsp_t;

  // Register kinds for decode
  typedef enum logic [1:0] {
    FST_KIND_NONE,
    FST_KIND_BYTE,
    FST_KIND_WORD,
    FST_KIND_SEND
  } fst_kind_t;

endpackage : fst_pkg

// ==== fst_fault_status_alert.sv ====
// Behaviour
// - Overcurrent comparator runs only while enabled
// - Overvoltage comparator runs only while enabled
// - Undervoltage comparator runs only while enabled
// - Per-pin polarity bit selects active level
// - Force bit drives pin active regardless
// - Clear-faults command resets all status registers
// - Overvoltage warning latches, write one clears
// - Undervoltage warning latches, write one clears
// - Overcurrent warning latches, write one clears
// - Over-temperature warning latches, write one clears
// - Unsupported command flag latches, write one clears
// - Unsupported data flag latches, write one clears
// - Packet check error flag latches, clearable
// - General link error flag latches, clearable
// - Busy flag latches, write one clears
// - Summary temperature bit equals over-temperature flag
// - Comm summary latches on any comm error
// - Status word layout: summaries, zeros, byte
// - Output voltage summary latches on either warning
// - All alert sources masked after reset
`timescale 1ns/10ps
`default_nettype none
`include "fst_params.svh"

module fst_fault_status_alert
  import fst_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic     MCLK,
  input  wire logic     RST,
  input  wire fst_cmd_t CMD,
  output var  fst_rsp_t RSP,
  input  wire logic     OV_CMP,
  input  wire logic     UV_CMP,
  input  wire logic     OC_CMP,
  input  wire logic     OT_IN,
  input  wire logic     BUSY_IN,
  output logic          OVERCURRENT_COMPARATOR_ENABLE,
  output logic          OVERVOLTAGE_COMPARATOR_ENABLE,
  output logic          UNDERVOLTAGE_COMPARATOR_ENABLE,
  output logic          OPEN_DRAIN_ALERT_PIN_O,
  output logic          OPEN_DRAIN_ALERT_PIN_OE,
  output logic          PUSH_PULL_ALERT_PIN_O,
  output logic          PUSH_PULL_ALERT_PIN_OE
);

  // ==========================================================
  // Decode helpers
  function automatic fst_kind_t reg_kind(input logic [7:0] code);
    case (code)
      `FST_CMD_CLEAR_FAULTS:   reg_kind = FST_KIND_SEND;
      `FST_CMD_STATUS_WORD,
      `FST_CMD_ALERT1_MASK,
      `FST_CMD_ALERT2_MASK,
      `FST_CMD_CFG_INTR:       reg_kind = FST_KIND_WORD;
      `FST_CMD_STATUS_BYTE,
      `FST_CMD_BUS_VOLTAGE_FAULT_STATUS,
      `FST_CMD_OVERCURRENT_FAULT_STATUS,
      `FST_CMD_STATUS_TEMP,
      `FST_CMD_COMM_ERROR_STATUS,
      `FST_CMD_ALERT_POLFORCE: reg_kind = FST_KIND_BYTE;
      default:                 reg_kind = FST_KIND_NONE;
    endcase
  endfunction : reg_kind

  function automatic logic wr_one(input fst_cmd_t c, input logic [7:0] code, input int b);
    wr_one = c.valid && c.write && (c.code == code) && c.data[b];
  endfunction : wr_one

  // ==========================================================
  // Pin input synchronisers
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] clean_ff;

  assign raw_in = {OT_IN, OC_CMP, UV_CMP, OV_CMP};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] stage_ff;
      // Three-stage chain, first stage read only by the second
      always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
          stage_ff <= '0;
        end else begin
          stage_ff <= {stage_ff[SYNC_STAGES-2:0], raw_in[gi]};
        end
      end
      // Accept a change once the last two stages agree
      always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
          clean_ff[gi] <= 1'b0;
        end else if (stage_ff[1] == stage_ff[2]) begin
          clean_ff[gi] <= stage_ff[2];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Configuration registers
  logic [2:0]  cfg_en_ff;
  logic [3:0]  polforce_ff;
  logic [15:0] mask1_ff;
  logic [15:0] mask2_ff;

  // Comparator enables from host writes
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg_en_ff <= `FST_RST_CFG;
    end else if (CMD.valid && CMD.write && CMD.code == `FST_CMD_CFG_INTR) begin
      cfg_en_ff <= CMD.data[2:0];
    end
  end

  // Polarity and force bits
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      polforce_ff <= `FST_RST_POLFORCE;
    end else if (CMD.valid && CMD.write && !CMD.word &&
                 CMD.code == `FST_CMD_ALERT_POLFORCE) begin
      polforce_ff <= CMD.data[3:0];
    end
  end

  // Alert masks, all sources masked out of reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mask1_ff <= `FST_RST_MASK;
      mask2_ff <= `FST_RST_MASK;
    end else if (CMD.valid && CMD.write && CMD.word) begin
      if (CMD.code == `FST_CMD_ALERT1_MASK) begin
        mask1_ff <= CMD.data;
      end
      if (CMD.code == `FST_CMD_ALERT2_MASK) begin
        mask2_ff <= CMD.data;
      end
    end
  end

  logic overcurrent_comparator_enable;
  logic overvoltage_comparator_enable;
  logic undervoltage_comparator_enable;
  assign overcurrent_comparator_enable = cfg_en_ff[`FST_BIT_OVERCURRENT_COMPARATOR_ENABLE];
  assign overvoltage_comparator_enable = cfg_en_ff[`FST_BIT_OVERVOLTAGE_COMPARATOR_ENABLE];
  assign undervoltage_comparator_enable = cfg_en_ff[`FST_BIT_UNDERVOLTAGE_COMPARATOR_ENABLE];

  // Comparator power follows enables
  assign OVERCURRENT_COMPARATOR_ENABLE  = overcurrent_comparator_enable;
  assign OVERVOLTAGE_COMPARATOR_ENABLE  = overvoltage_comparator_enable;
  assign UNDERVOLTAGE_COMPARATOR_ENABLE = undervoltage_comparator_enable;

  // ==========================================================
  // Fault events; a disabled comparator reports nothing
  logic ev_ov;
  logic ev_uv;
  logic ev_oc;
  logic ev_ot;
  assign ev_ov = clean_ff[0] && overvoltage_comparator_enable;
  assign ev_uv = clean_ff[1] && undervoltage_comparator_enable;
  assign ev_oc = clean_ff[2] && overcurrent_comparator_enable;
  assign ev_ot = clean_ff[3];

  // Communication error events from the transaction decode
  fst_kind_t kind;
  logic      ev_unsupported_command_flag;
  logic      ev_unsupported_payload_flag;
  logic      ev_pec;
  logic      ev_general_link_error_flag;
  assign kind      = reg_kind(CMD.code);
  assign ev_unsupported_command_flag  = CMD.valid && (kind == FST_KIND_NONE);
  assign ev_unsupported_payload_flag = CMD.valid && CMD.write && CMD.word && (kind == FST_KIND_BYTE);
  assign ev_pec    = CMD.valid && CMD.pec_bad;
  assign ev_general_link_error_flag = CMD.valid && !CMD.write && (kind == FST_KIND_SEND);

  logic clr_all;
  assign clr_all = CMD.valid && CMD.write && (CMD.code == `FST_CMD_CLEAR_FAULTS);

  // Write strobes: any host write, and a write to the status word
  logic wb;
  logic ww;
  assign wb = CMD.valid && CMD.write;
  assign ww = CMD.valid && CMD.write && (CMD.code == `FST_CMD_STATUS_WORD);

  // ==========================================================
  // Latched status flags, set wins over any clear
  logic ov_ff;
  logic uv_ff;
  logic oc_ff;
  logic ot_ff;
  logic unsupported_command_flag_ff;
  logic unsupported_payload_flag_ff;
  logic pec_ff;
  logic general_link_error_flag_ff;
  logic busy_ff;
  logic cml_sum_ff;
  logic vout_sum_ff;

  // Bus voltage warnings
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ov_ff <= 1'b0;
      uv_ff <= 1'b0;
    end else begin
      if (ev_ov) begin
        ov_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_BUS_VOLTAGE_FAULT_STATUS, `FST_BIT_VOUT_OV)) begin
        ov_ff <= 1'b0;
      end
      if (ev_uv) begin
        uv_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_BUS_VOLTAGE_FAULT_STATUS, `FST_BIT_VOUT_UV)) begin
        uv_ff <= 1'b0;
      end
    end
  end

  // Overcurrent warning, also the word's current summary
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      oc_ff <= 1'b0;
    end else if (ev_oc) begin
      oc_ff <= 1'b1;
    end else if (clr_all || wr_one(CMD, `FST_CMD_OVERCURRENT_FAULT_STATUS, `FST_BIT_IOUT_OC) ||
                 (ww && CMD.data[`FST_BIT_SW_IOUT])) begin
      oc_ff <= 1'b0;
    end
  end

  // Over-temperature, shared with the summary temperature bit
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ot_ff <= 1'b0;
    end else if (ev_ot) begin
      ot_ff <= 1'b1;
    end else if (clr_all || wr_one(CMD, `FST_CMD_STATUS_TEMP, `FST_BIT_TEMP_OT) ||
                 wr_one(CMD, `FST_CMD_STATUS_BYTE, `FST_BIT_SB_TEMP) ||
                 (ww && CMD.data[`FST_BIT_SB_TEMP])) begin
      ot_ff <= 1'b0;
    end
  end

  // Communication error flags
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      unsupported_command_flag_ff  <= 1'b0;
      unsupported_payload_flag_ff <= 1'b0;
      pec_ff    <= 1'b0;
      general_link_error_flag_ff <= 1'b0;
    end else begin
      if (ev_unsupported_command_flag) begin
        unsupported_command_flag_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_COMM_ERROR_STATUS, `FST_BIT_CML_UNSUPPORTED_COMMAND_FLAG)) begin
        unsupported_command_flag_ff <= 1'b0;
      end
      if (ev_unsupported_payload_flag) begin
        unsupported_payload_flag_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_COMM_ERROR_STATUS, `FST_BIT_CML_UNSUPPORTED_PAYLOAD_FLAG)) begin
        unsupported_payload_flag_ff <= 1'b0;
      end
      if (ev_pec) begin
        pec_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_COMM_ERROR_STATUS, `FST_BIT_CML_PEC)) begin
        pec_ff <= 1'b0;
      end
      if (ev_general_link_error_flag) begin
        general_link_error_flag_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_COMM_ERROR_STATUS, `FST_BIT_CML_GENERAL_LINK_ERROR_FLAG)) begin
        general_link_error_flag_ff <= 1'b0;
      end
    end
  end

  // Summary byte: busy and communication roll-up
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      busy_ff    <= 1'b0;
      cml_sum_ff <= 1'b0;
    end else begin
      if (BUSY_IN) begin
        busy_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_STATUS_BYTE, `FST_BIT_SB_BUSY) ||
                   (ww && CMD.data[`FST_BIT_SB_BUSY])) begin
        busy_ff <= 1'b0;
      end
      if (ev_unsupported_command_flag || ev_unsupported_payload_flag || ev_pec || ev_general_link_error_flag) begin
        cml_sum_ff <= 1'b1;
      end else if (clr_all || wr_one(CMD, `FST_CMD_STATUS_BYTE, `FST_BIT_SB_CML) ||
                   (ww && CMD.data[`FST_BIT_SB_CML])) begin
        cml_sum_ff <= 1'b0;
      end
    end
  end

  // Output voltage summary in the status word
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      vout_sum_ff <= 1'b0;
    end else if (ev_ov || ev_uv) begin
      vout_sum_ff <= 1'b1;
    end else if (clr_all || (ww && CMD.data[`FST_BIT_SW_VOUT])) begin
      vout_sum_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Register images
  logic [7:0]  st_vout;
  logic [7:0]  st_iout;
  logic [7:0]  st_temp;
  logic [7:0]  st_cml;
  logic [7:0]  st_byte;
  logic [15:0] st_word;

  always_comb begin
    st_vout = `FST_RST_STATUS;
    st_iout = `FST_RST_STATUS;
    st_temp = `FST_RST_STATUS;
    st_cml  = `FST_RST_STATUS;
    st_byte = `FST_RST_STATUS;
    st_vout[`FST_BIT_VOUT_OV]    = ov_ff;
    st_vout[`FST_BIT_VOUT_UV]    = uv_ff;
    st_iout[`FST_BIT_IOUT_OC]    = oc_ff;
    st_temp[`FST_BIT_TEMP_OT]    = ot_ff;
    st_cml[`FST_BIT_CML_UNSUPPORTED_COMMAND_FLAG]   = unsupported_command_flag_ff;
    st_cml[`FST_BIT_CML_UNSUPPORTED_PAYLOAD_FLAG]  = unsupported_payload_flag_ff;
    st_cml[`FST_BIT_CML_PEC]     = pec_ff;
    st_cml[`FST_BIT_CML_GENERAL_LINK_ERROR_FLAG]  = general_link_error_flag_ff;
    st_byte[`FST_BIT_SB_BUSY]    = busy_ff;
    st_byte[`FST_BIT_SB_TEMP]    = ot_ff;
    st_byte[`FST_BIT_SB_CML]     = cml_sum_ff;
    st_word = {vout_sum_ff, oc_ff, 6'h00, st_byte};
  end

  // ==========================================================
  // Read answer, one cycle after the request
  logic [15:0] nxt_rdata;
  always_comb begin
    case (CMD.code)
      `FST_CMD_STATUS_BYTE:    nxt_rdata = {8'h00, st_byte};
      `FST_CMD_STATUS_WORD:    nxt_rdata = st_word;
      `FST_CMD_BUS_VOLTAGE_FAULT_STATUS:    nxt_rdata = {8'h00, st_vout};
      `FST_CMD_OVERCURRENT_FAULT_STATUS:    nxt_rdata = {8'h00, st_iout};
      `FST_CMD_STATUS_TEMP:    nxt_rdata = {8'h00, st_temp};
      `FST_CMD_COMM_ERROR_STATUS:     nxt_rdata = {8'h00, st_cml};
      `FST_CMD_CFG_INTR:       nxt_rdata = {13'h0000, cfg_en_ff};
      `FST_CMD_ALERT_POLFORCE: nxt_rdata = {12'h000, polforce_ff};
      `FST_CMD_ALERT1_MASK:    nxt_rdata = mask1_ff;
      `FST_CMD_ALERT2_MASK:    nxt_rdata = mask2_ff;
      default:                 nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RSP <= '0;
    end else begin
      RSP.valid <= CMD.valid && !CMD.write;
      RSP.data  <= (CMD.valid && !CMD.write) ? nxt_rdata : 16'h0000;
    end
  end

  // ==========================================================
  // Alert pin drive
  logic act1;
  logic act2;
  logic lvl1;
  logic lvl2;
  assign act1 = polforce_ff[`FST_BIT_FIRST_ALERT_FORCE] || (|(st_word & ~mask1_ff));
  assign act2 = polforce_ff[`FST_BIT_SECOND_ALERT_FORCE] || (|(st_word & ~mask2_ff));
  assign lvl1 = act1 ? polforce_ff[`FST_BIT_FIRST_ALERT_POLARITY] : !polforce_ff[`FST_BIT_FIRST_ALERT_POLARITY];
  assign lvl2 = act2 ? polforce_ff[`FST_BIT_SECOND_ALERT_POLARITY] : !polforce_ff[`FST_BIT_SECOND_ALERT_POLARITY];

  // Registered pins; open drain only ever pulls low
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      OPEN_DRAIN_ALERT_PIN_O  <= 1'b0;
      OPEN_DRAIN_ALERT_PIN_OE <= 1'b0;
      PUSH_PULL_ALERT_PIN_O   <= 1'b1;
      PUSH_PULL_ALERT_PIN_OE  <= 1'b1;
    end else begin
      OPEN_DRAIN_ALERT_PIN_O  <= 1'b0;
      OPEN_DRAIN_ALERT_PIN_OE <= !lvl1;
      PUSH_PULL_ALERT_PIN_O   <= lvl2;
      PUSH_PULL_ALERT_PIN_OE  <= 1'b1;
    end
  end

endmodule : fst_fault_status_alert

`default_nettype wire

// ==== fst_fault_status_alert_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker for status and alert block
module fst_checker
  import fst_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input wire logic     MCLK,
  input wire logic     RST,
  input wire fst_cmd_t CMD,
  input wire fst_rsp_t RSP,
  input wire logic     BUSY_IN,
  input wire logic     OVERCURRENT_COMPARATOR_ENABLE,
  input wire logic     OVERVOLTAGE_COMPARATOR_ENABLE,
  input wire logic     UNDERVOLTAGE_COMPARATOR_ENABLE,
  input wire logic     OPEN_DRAIN_ALERT_PIN_OE,
  input wire logic     PUSH_PULL_ALERT_PIN_O
);
  // Request kinds
  wire rd_req = CMD.valid && !CMD.write;
  wire wr_req = CMD.valid && CMD.write;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  property p_oc_enable;
    wr_req && CMD.word && CMD.code == 8'hDD
      |=> OVERCURRENT_COMPARATOR_ENABLE == $past(CMD.data[2]);
  endproperty
  a_oc_enable: assert property (p_oc_enable)
    else $error("overcurrent enable not taken from write");

  property p_ov_uv_enable;
    wr_req && CMD.word && CMD.code == 8'hDD |=> OVERVOLTAGE_COMPARATOR_ENABLE ==
      $past(CMD.data[1]) && UNDERVOLTAGE_COMPARATOR_ENABLE == $past(CMD.data[0]);
  endproperty
  a_ov_uv_enable: assert property (p_ov_uv_enable)
    else $error("voltage enables not taken from write");

  property p_pp_force;
    wr_req && !CMD.word && CMD.code == 8'hDE && CMD.data[1]
      |-> ##3 PUSH_PULL_ALERT_PIN_O == $past(CMD.data[3], 3);
  endproperty
  a_pp_force: assert property (p_pp_force)
    else $error("forced push-pull pin not at active level");

  property p_od_force;
    wr_req && !CMD.word && CMD.code == 8'hDE && CMD.data[0]
      |-> ##3 OPEN_DRAIN_ALERT_PIN_OE == !$past(CMD.data[2], 3);
  endproperty
  a_od_force: assert property (p_od_force)
    else $error("forced open-drain pin not at active level");

  property p_clear_faults;
    wr_req && !CMD.word && !CMD.pec_bad && CMD.code == 8'h03 ##1
      rd_req && !CMD.pec_bad && CMD.code == 8'h7E |=> RSP.data == 16'h0000;
  endproperty
  a_clear_faults: assert property (p_clear_faults)
    else $error("comm status not cleared by clear command");

  property p_unsup_cmd;
    rd_req && CMD.code == 8'h55 ##1 rd_req && CMD.code == 8'h7E |=> RSP.data[7];
  endproperty
  a_unsup_cmd: assert property (p_unsup_cmd)
    else $error("unknown command not flagged");

  property p_unsup_data;
    wr_req && CMD.word && CMD.code == 8'h7A ##1 rd_req && CMD.code == 8'h7E
      |=> RSP.data[6];
  endproperty
  a_unsup_data: assert property (p_unsup_data)
    else $error("word to byte register not flagged");

  property p_busy;
    BUSY_IN ##1 rd_req && CMD.code == 8'h78 |=> RSP.data[7];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy input not latched");

  property p_word_layout;
    rd_req && CMD.code == 8'h79 |=> RSP.valid && RSP.data[13:8] == 6'h00;
  endproperty
  a_word_layout: assert property (p_word_layout)
    else $error("status word reserved bits not zero");
endmodule : fst_checker

bind fst_fault_status_alert fst_checker #(.SYNC_STAGES(SYNC_STAGES)) fst_checker_inst (
  .MCLK                          (MCLK),
  .RST                           (RST),
  .CMD                           (CMD),
  .RSP                           (RSP),
  .BUSY_IN                       (BUSY_IN),
  .OVERCURRENT_COMPARATOR_ENABLE (OVERCURRENT_COMPARATOR_ENABLE),
  .OVERVOLTAGE_COMPARATOR_ENABLE (OVERVOLTAGE_COMPARATOR_ENABLE),
  .UNDERVOLTAGE_COMPARATOR_ENABLE(UNDERVOLTAGE_COMPARATOR_ENABLE),
  .OPEN_DRAIN_ALERT_PIN_OE       (OPEN_DRAIN_ALERT_PIN_OE),
  .PUSH_PULL_ALERT_PIN_O         (PUSH_PULL_ALERT_PIN_O)
);
`default_nettype wire

// ==== fst_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host side of the register link
module fst_host_model
  import fst_pkg::*;
(
  input  wire logic     mclk,
  output var  fst_cmd_t cmd,
  input  wire fst_rsp_t rsp,
  input  wire logic     od_o,
  input  wire logic     od_oe,
  input  wire logic     pp_o,
  input  wire logic     pp_oe,
  output logic          alert1_lvl,
  output logic          alert2_lvl
);
  logic [15:0] rsp_q [$];

  // Open drain has a pull-up, released push-pull shows the inverse
  assign alert1_lvl = od_oe ? od_o : 1'b1;
  assign alert2_lvl = pp_oe ? pp_o : ~pp_o;

  // Keep each read answer in the cycle it stands
  always @(posedge mclk) begin
    if (rsp.valid) begin
      rsp_q.push_back(rsp.data);
    end
  end

  initial cmd = '0;

  // Launch one request just after an edge
  task automatic send(input logic w, input logic wd, input logic pec,
                      input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk);
    #1 cmd = {1'b1, w, wd, pec, code, data};
  endtask : send

  // Drop the request once it was taken
  task automatic idle();
    @(posedge mclk);
    #1 cmd = '0;
  endtask : idle
endmodule : fst_host_model
`default_nettype wire

// ==== tb_fault_status_alert_control.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench for status and alert block
module tb_fault_status_alert_control
  import fst_pkg::*;
;
  logic     mclk, rst, ov_cmp, uv_cmp, oc_cmp, ot_in, busy_in;
  logic     overcurrent_comparator_enable, overvoltage_comparator_enable, undervoltage_comparator_enable, od_o, od_oe, pp_o, pp_oe, al1, al2;
  fst_cmd_t cmd;
  fst_rsp_t rsp;
  int       failures, n_tests;
  logic [7:0]  regs [8] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7D, 8'h7E, 8'hDE, 8'hDD};
  fst_cmd_t    ev   [4] = '{28'h8550000, 28'hE7A0000, 28'hD7A0000, 28'h8030000};
  logic [7:0]  ev_b [4] = '{8'h80, 8'h40, 8'h20, 8'h02};
  logic [7:0]  pf   [4] = '{8'hF3, 8'h0F, 8'h0C, 8'h00};
  logic [1:0]  pf_x [4] = '{2'b00, 2'b11, 2'b00, 2'b11};

  fst_fault_status_alert fst_fault_status_alert_inst (
    .MCLK(mclk), .RST(rst), .CMD(cmd), .RSP(rsp), .OV_CMP(ov_cmp), .UV_CMP(uv_cmp),
    .OC_CMP(oc_cmp), .OT_IN(ot_in), .BUSY_IN(busy_in), .OVERCURRENT_COMPARATOR_ENABLE(overcurrent_comparator_enable),
    .OVERVOLTAGE_COMPARATOR_ENABLE(overvoltage_comparator_enable), .UNDERVOLTAGE_COMPARATOR_ENABLE(undervoltage_comparator_enable),
    .OPEN_DRAIN_ALERT_PIN_O(od_o), .OPEN_DRAIN_ALERT_PIN_OE(od_oe),
    .PUSH_PULL_ALERT_PIN_O(pp_o), .PUSH_PULL_ALERT_PIN_OE(pp_oe));
  fst_host_model host_inst (.mclk(mclk), .cmd(cmd), .rsp(rsp), .od_o(od_o), .od_oe(od_oe),
    .pp_o(pp_o), .pp_oe(pp_oe), .alert1_lvl(al1), .alert2_lvl(al2));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Register access and pin tasks
  task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic wd);
    host_inst.send(1'b1, wd, 1'b0, code, data);
    host_inst.idle();
  endtask : wr
  task automatic last(input logic [7:0] code, input logic [15:0] exp);
    repeat (2) @(posedge mclk);
    chk($sformatf("reg %h", code), exp,
        host_inst.rsp_q.size() > 0 ? host_inst.rsp_q[$] : 16'hXXXX);
    host_inst.rsp_q.delete();
  endtask : last
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    host_inst.send(1'b0, 1'b0, 1'b0, code, 16'h0000);
    host_inst.idle();
    last(code, exp);
  endtask : rd
  task automatic pins(input logic [1:0] exp);
    repeat (4) @(posedge mclk);
    #1;
    chk("alert pins", {14'h0000, exp}, {14'h0000, al2, al1});
  endtask : pins
  task automatic en(input logic [2:0] exp);
    chk("enables", {13'h0000, exp}, {13'h0000, overcurrent_comparator_enable, overvoltage_comparator_enable, undervoltage_comparator_enable});
  endtask : en
  task automatic drive(input logic [4:0] v);
    @(posedge mclk);
    #1 {ov_cmp, uv_cmp, oc_cmp, ot_in, busy_in} = v;
    repeat (8) @(posedge mclk);
  endtask : drive

  // Verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Watchdog
  initial begin
    #50000;
    failures++;
    wrap_up();
  end

  // Test sequence
  initial begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    {ov_cmp, uv_cmp, oc_cmp, ot_in, busy_in} = 5'h00;
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    foreach (regs[i]) rd(regs[i], 16'h0000);
    drive(5'h01);
    pins(2'b11);
    rd(8'h78, 16'h0080);
    drive(5'h00);
    wr(8'h78, 16'h0000, 1'b0);
    rd(8'h78, 16'h0080);
    wr(8'h78, 16'h0080, 1'b0);
    rd(8'h78, 16'h0000);
    $display("test reset and busy done");
    drive(5'h1C);
    drive(5'h00);
    rd(8'h7A, 16'h0000);
    rd(8'h7B, 16'h0000);
    wr(8'hDD, 16'h0007, 1'b1);
    en(3'h7);
    wr(8'hDD, 16'h0002, 1'b1);
    en(3'h2);
    wr(8'hDD, 16'h0007, 1'b1);
    $display("test enables done");
    drive(5'h16);
    drive(5'h00);
    rd(8'h7A, 16'h0040);
    rd(8'h7B, 16'h0020);
    rd(8'h7D, 16'h0040);
    rd(8'h78, 16'h0004);
    rd(8'h79, 16'hC004);
    drive(5'h08);
    drive(5'h00);
    rd(8'h7A, 16'h0060);
    wr(8'h7A, 16'h0040, 1'b0);
    rd(8'h7A, 16'h0020);
    wr(8'h79, 16'h8000, 1'b1);
    rd(8'h79, 16'h4004);
    wr(8'h7D, 16'h0040, 1'b0);
    rd(8'h78, 16'h0000);
    wr(8'h7B, 16'h0020, 1'b0);
    rd(8'h79, 16'h0000);
    $display("test fault latches done");
    host_inst.send(1'b0, 1'b0, 1'b0, 8'h55, 16'h0000);
    host_inst.send(1'b1, 1'b0, 1'b0, 8'h03, 16'h0000);
    host_inst.send(1'b0, 1'b0, 1'b0, 8'h7E, 16'h0000);
    host_inst.idle();
    last(8'h7E, 16'h0000);
    rd(8'h7A, 16'h0000);
    rd(8'h78, 16'h0000);
    $display("test clear faults done");
    foreach (ev[i]) begin
      host_inst.send(ev[i].write, ev[i].word, ev[i].pec_bad, ev[i].code, ev[i].data);
      host_inst.send(1'b0, 1'b0, 1'b0, 8'h7E, 16'h0000);
      host_inst.idle();
      last(8'h7E, {8'h00, ev_b[i]});
      rd(8'h78, 16'h0002);
      wr(8'h7E, {8'h00, ev_b[i]}, 1'b0);
      wr(8'h78, 16'h0002, 1'b0);
      rd(8'h7E, 16'h0000);
      rd(8'h78, 16'h0000);
    end
    $display("test comm errors done");
    foreach (pf[i]) begin
      wr(8'hDE, {8'h00, pf[i]}, 1'b0);
      rd(8'hDE, {12'h000, pf[i][3:0]});
      pins(pf_x[i]);
    end
    wr(8'hDF, 16'hFFFB, 1'b1);
    drive(5'h02);
    pins(2'b01);
    drive(5'h00);
    wr(8'h7D, 16'h0040, 1'b0);
    pins(2'b11);
    $display("test alert pins done");
    wr(8'hDE, 16'h000C, 1'b0);
    @(posedge mclk);
    #1 rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    pins(2'b11);
    rd(8'hDE, 16'h0000);
    en(3'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_fault_status_alert_control
`default_nettype wire
